// file: rtl/sdram_area3_pkg.sv
// Operation
// - after write, four idle cycles before access
// - read-write and read-read idle codes, 11 gives four
// - type code 100 makes area three SDRAM
// - bus size code 10 selects 16-bit bus
// - precharge recovery 00: one idle before activate
// - row-to-column 01: two idle before read/write
// - CAS latency 01: read data after two cycles
// - write recovery 00: no idle before precharge
// - refresh recovery 00: three idle before activate
// - counter equal to compare raises refresh request
// - compare write needs key in upper half
// - counter and control writes need the key
// - counter counts on selected prescaled clock
// - clock select 001 counts at quarter rate
// - refresh count 000 gives one refresh per match
// - bit 7 match flag, bit 6 gates interrupt
// - refresh enable bit 11, bit 10 picks self-refresh
// - bank-active 0 means auto-precharge on each access
// - area two row/column width codes 00: 11/8
// - area three row 01 is 12, column 00 is 8
// - keyed write of 00 clears the counter
// - mode program: precharge all, eight refreshes, mode write
`default_nettype none
package sdram_area3_pkg;
  localparam int          REG_ADDR_W       = 8;
  localparam logic [7:0]  BUS_CONTROL_OFF  = 8'h00;
  localparam logic [7:0]  WAIT_CONTROL_OFF = 8'h04;
  localparam logic [7:0]  SDRAM_CONTROL_OFF= 8'h08;
  localparam logic [7:0]  REFRESH_CSR_OFF  = 8'h0c;
  localparam logic [7:0]  REFRESH_CNT_OFF  = 8'h10;
  localparam logic [7:0]  REFRESH_CMP_OFF  = 8'h14;
  localparam logic [7:0]  MODE_PROGRAM_OFF = 8'h18;
  localparam logic [7:0]  STATUS_OFF       = 8'h1c;
  localparam logic [15:0] WRITE_KEY        = 16'ha55a;
  localparam logic [31:0] BUS_CONTROL_RST  = 32'h36db4400;
  localparam logic [31:0] BUS_CONTROL_MASK = 32'h36db7600;
  localparam logic [31:0] WAIT_CONTROL_RST = 32'h00000480;
  localparam logic [31:0] WAIT_CONTROL_MASK= 32'h00006d9b;
  localparam logic [31:0] SDRAM_CTRL_RST   = 32'h00000808;
  localparam logic [31:0] SDRAM_CTRL_MASK  = 32'h001b0d1b;
  localparam logic [7:0]  REFRESH_CMP_RST  = 8'h9c;
  localparam logic [2:0]  CLOCK_SELECT_RST = 3'b001;
  localparam int W_IDLE_POS = 28;
  localparam int RW_OTHER_POS = 25;
  localparam int RW_SAME_POS = 22;
  localparam int RR_OTHER_POS = 19;
  localparam int RR_SAME_POS = 16;
  localparam int TYPE_POS = 12;
  localparam int WIDTH_POS = 9;
  localparam logic [2:0] TYPE_SDRAM = 3'b100;
  localparam logic [1:0] WIDTH_16BIT = 2'b10;
  localparam int PRE_GAP_POS = 13;
  localparam int ROW_COL_POS = 10;
  localparam int CL_POS = 7;
  localparam int WR_REC_POS = 3;
  localparam int REF_REC_POS = 0;
  localparam int AREA2_ROW_POS = 19;
  localparam int AREA2_COL_POS = 16;
  localparam int REFRESH_ON_POS = 11;
  localparam int SELF_KIND_POS = 10;
  localparam int BANK_OPEN_POS = 8;
  localparam int AREA3_ROW_POS = 3;
  localparam int AREA3_COL_POS = 0;
  localparam int MATCH_FLAG_POS = 7;
  localparam int MATCH_IE_POS = 6;
  localparam int CLK_SEL_POS = 3;
  localparam int REF_CNT_POS = 0;
  localparam logic [3:0] REF_REC_BASE = 4'd3;
  localparam logic [3:0] MODE_REFRESHES = 4'd8;
  localparam int AP_BIT = 10;
  localparam logic [3:0] CMD_NOP = 4'b0111;
  localparam logic [3:0] CMD_ACT = 4'b0011;
  localparam logic [3:0] CMD_READ = 4'b0101;
  localparam logic [3:0] CMD_WRITE = 4'b0100;
  localparam logic [3:0] CMD_PRE = 4'b0010;
  localparam logic [3:0] CMD_REF = 4'b0001;
  localparam logic [3:0] CMD_MRS = 4'b0000;
  typedef enum logic [3:0] {
    S_IDLE, S_WAIT, S_RW, S_RDCAP, S_PRE, S_FIN, S_MREF, S_MRS, S_SELF
  } seq_state_type;
endpackage
`default_nettype wire

// file: rtl/refresh_interval_timer.sv
`default_nettype none
module refresh_interval_timer (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic [2:0] clock_select_in,
  input  wire logic [7:0] compare_in,
  input  wire logic       load_in,
  input  wire logic [7:0] load_value_in,
  output logic      [7:0] count_out,
  output logic            match_out
);
  logic [11:0] pre_q;
  logic [11:0] div_mask;
  logic        tick;

  always_comb begin
    unique case (clock_select_in)
      3'd1:    div_mask = 12'h003;
      3'd2:    div_mask = 12'h00f;
      3'd3:    div_mask = 12'h03f;
      3'd4:    div_mask = 12'h0ff;
      3'd5:    div_mask = 12'h3ff;
      3'd6:    div_mask = 12'h7ff;
      default: div_mask = 12'hfff;
    endcase
  end
  assign tick = (clock_select_in != 3'd0) && ((pre_q & div_mask) == div_mask);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pre_q <= 12'h000;
    end else begin
      pre_q <= pre_q + 12'h001;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_out <= 8'h00;
      match_out <= 1'b0;
    end else begin
      match_out <= 1'b0;
      if (load_in) begin
        count_out <= load_value_in;
      end else if (tick) begin
        if (count_out == compare_in) begin
          count_out <= 8'h00;
          match_out <= 1'b1;
        end else begin
          count_out <= count_out + 8'h01;
        end
      end
    end
  end

  property p_match_restart;
    @(posedge clk_in) disable iff (rst_in)
    (tick && !load_in && count_out == compare_in) |=> (match_out && count_out == 8'h00);
  endproperty
  a_match_restart: assert property (p_match_restart)
    else $error("match did not restart the counter");

  property p_quarter_rate;
    @(posedge clk_in) disable iff (rst_in || clock_select_in != 3'd1)
    tick |=> (!tick)[*3] ##1 tick;
  endproperty
  a_quarter_rate: assert property (p_quarter_rate)
    else $error("quarter rate tick spacing wrong");
endmodule // refresh_interval_timer
`default_nettype wire

// file: rtl/sdram_area3_bus_controller.sv
`default_nettype none
module sdram_area3_bus_controller (
  input  wire logic                                 clk_in,
  input  wire logic                                 rst_in,
  input  wire logic [sdram_area3_pkg::REG_ADDR_W-1:0] reg_addr_in,
  input  wire logic [31:0]                          reg_wdata_in,
  input  wire logic                                 reg_write_in,
  input  wire logic                                 reg_read_in,
  output logic      [31:0]                          reg_rdata_out,
  input  wire logic                                 acc_req_in,
  input  wire logic                                 acc_write_in,
  input  wire logic [23:0]                          acc_addr_in,
  input  wire logic [15:0]                          acc_wdata_in,
  output logic                                      acc_busy_out,
  output logic                                      acc_done_out,
  output logic      [15:0]                          acc_rdata_out,
  output logic                                      sd_cke_out,
  output logic                                      sd_cs_n_out,
  output logic                                      sd_ras_n_out,
  output logic                                      sd_cas_n_out,
  output logic                                      sd_we_n_out,
  output logic      [1:0]                           sd_ba_out,
  output logic      [12:0]                          sd_addr_out,
  input  wire logic [15:0]                          sd_dq_in,
  output logic      [15:0]                          sd_dq_out,
  output logic                                      sd_dq_oe_n_out,
  output logic                                      cmi_req_out
);
  import sdram_area3_pkg::*;

  logic [31:0]   bus_ctrl_q, wait_ctrl_q, sdram_ctrl_q;
  logic [7:0]    cmp_q, count;
  logic          flag_q, irq_en_q, match;
  logic [2:0]    clk_sel_q, per_match_q;
  logic [12:0]   mode_value_q;
  logic          mode_pend_q;
  logic [3:0]    cmd_q, wait_q, mref_q, ref_pend_q;
  seq_state_type state_q, ret_q;
  logic [15:0]   dq_s1_q, dq_s2_q;
  logic          pend_write_q, last_valid_q, last_write_q;
  logic [23:0]   pend_addr_q;
  logic [15:0]   pend_wdata_q;
  logic [2:0]    idle_cnt_q;
  logic          key_ok, wr_csr, wr_cnt, wr_cmp, take;
  logic          is_sdram, bus16, auto_ap, auto_ref, self_ref;
  logic          self_go, mode_go, ref_go, acc_go, acc_skip;
  logic [3:0]    pre_gap, rcd_gap, cl, wr_gap, ref_gap;
  logic [2:0]    need;
  logic [4:0]    col_w, row_w;
  logic [23:0]   row_full, bank_full;
  logic [12:0]   row;
  logic [9:0]    col;

  function automatic logic [2:0] idle_of(input logic [1:0] code);
    idle_of = (code == 2'd3) ? 3'd4 : {1'b0, code};
  endfunction

  assign is_sdram = bus_ctrl_q[TYPE_POS +: 3] == TYPE_SDRAM;
  assign bus16 = bus_ctrl_q[WIDTH_POS +: 2] == WIDTH_16BIT;
  assign pre_gap = 4'd1 + {2'b00, wait_ctrl_q[PRE_GAP_POS +: 2]};
  assign rcd_gap = 4'd1 + {2'b00, wait_ctrl_q[ROW_COL_POS +: 2]};
  assign cl = 4'd1 + {2'b00, wait_ctrl_q[CL_POS +: 2]};
  assign wr_gap = {2'b00, wait_ctrl_q[WR_REC_POS +: 2]};
  assign ref_gap = REF_REC_BASE + {2'b00, wait_ctrl_q[REF_REC_POS +: 2]};
  assign auto_ap = !sdram_ctrl_q[BANK_OPEN_POS];
  assign auto_ref = sdram_ctrl_q[REFRESH_ON_POS] && !sdram_ctrl_q[SELF_KIND_POS];
  assign self_ref = sdram_ctrl_q[REFRESH_ON_POS] && sdram_ctrl_q[SELF_KIND_POS];

  // area three widths steer the split, area two widths are held for software
  assign col_w = (sdram_ctrl_q[AREA3_COL_POS +: 2] == 2'd3) ? 5'd10
               : 5'd8 + {3'b000, sdram_ctrl_q[AREA3_COL_POS +: 2]};
  assign row_w = (sdram_ctrl_q[AREA3_ROW_POS +: 2] == 2'd3) ? 5'd13
               : 5'd11 + {3'b000, sdram_ctrl_q[AREA3_ROW_POS +: 2]};
  assign col = pend_addr_q[9:0] & ~(10'h3ff << col_w);
  assign row_full = pend_addr_q >> col_w;
  assign row = row_full[12:0] & ~(13'h1fff << row_w);
  assign bank_full = row_full >> row_w;

  // only one space exists, so the same-space codes apply
  always_comb begin
    need = 3'd0;
    if (last_valid_q && last_write_q) begin
      need = idle_of(bus_ctrl_q[W_IDLE_POS +: 2]);
    end else if (last_valid_q && pend_write_q) begin
      need = idle_of(bus_ctrl_q[RW_SAME_POS +: 2]);
    end else if (last_valid_q) begin
      need = idle_of(bus_ctrl_q[RR_SAME_POS +: 2]);
    end
  end

  assign self_go = (state_q == S_IDLE) && self_ref;
  assign mode_go = (state_q == S_IDLE) && !self_ref && mode_pend_q;
  assign ref_go = (state_q == S_IDLE) && !self_ref && !mode_pend_q && auto_ref
               && (ref_pend_q != 4'd0);
  assign acc_go = (state_q == S_IDLE) && !self_ref && !mode_pend_q && !ref_go
               && acc_busy_out && is_sdram && bus16 && (idle_cnt_q >= need);
  assign acc_skip = (state_q == S_IDLE) && acc_busy_out && !(is_sdram && bus16);

  assign key_ok = reg_wdata_in[31:16] == WRITE_KEY;
  assign wr_cmp = reg_write_in && reg_addr_in == REFRESH_CMP_OFF && key_ok;
  assign wr_cnt = reg_write_in && reg_addr_in == REFRESH_CNT_OFF && key_ok;
  assign wr_csr = reg_write_in && reg_addr_in == REFRESH_CSR_OFF && key_ok;
  assign take = acc_req_in && !acc_busy_out;

  refresh_interval_timer timer (
    .clk_in          (clk_in),
    .rst_in          (rst_in),
    .clock_select_in (clk_sel_q),
    .compare_in      (cmp_q),
    .load_in         (wr_cnt),
    .load_value_in   (reg_wdata_in[7:0]),
    .count_out       (count),
    .match_out       (match)
  );

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      bus_ctrl_q <= BUS_CONTROL_RST;
      wait_ctrl_q <= WAIT_CONTROL_RST;
      sdram_ctrl_q <= SDRAM_CTRL_RST;
    end else if (reg_write_in) begin
      if (reg_addr_in == BUS_CONTROL_OFF) begin
        bus_ctrl_q <= reg_wdata_in & BUS_CONTROL_MASK;
      end
      if (reg_addr_in == WAIT_CONTROL_OFF) begin
        wait_ctrl_q <= reg_wdata_in & WAIT_CONTROL_MASK;
      end
      if (reg_addr_in == SDRAM_CONTROL_OFF) begin
        sdram_ctrl_q <= reg_wdata_in & SDRAM_CTRL_MASK;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cmp_q <= REFRESH_CMP_RST;
      irq_en_q <= 1'b0;
      clk_sel_q <= CLOCK_SELECT_RST;
      per_match_q <= 3'd0;
    end else begin
      if (wr_cmp) begin
        cmp_q <= reg_wdata_in[7:0];
      end
      if (wr_csr) begin
        irq_en_q <= reg_wdata_in[MATCH_IE_POS];
        clk_sel_q <= reg_wdata_in[CLK_SEL_POS +: 3];
        per_match_q <= reg_wdata_in[REF_CNT_POS +: 3];
      end
    end
  end

  // match flag: a keyed write of 0 clears it, a match in the same cycle wins
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      flag_q <= 1'b0;
      cmi_req_out <= 1'b0;
    end else begin
      if (match) begin
        flag_q <= 1'b1;
      end else if (wr_csr && !reg_wdata_in[MATCH_FLAG_POS]) begin
        flag_q <= 1'b0;
      end
      cmi_req_out <= flag_q && irq_en_q;
    end
  end

  // pending refreshes: each match adds the programmed count plus one
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ref_pend_q <= 4'd0;
    end else begin
      ref_pend_q <= ref_pend_q + (match ? {1'b0, per_match_q} + 4'd1 : 4'd0)
                    - (ref_go ? 4'd1 : 4'd0);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_value_q <= 13'h0000;
      mode_pend_q <= 1'b0;
    end else if (reg_write_in && reg_addr_in == MODE_PROGRAM_OFF) begin
      mode_value_q <= reg_wdata_in[12:0];
      mode_pend_q <= 1'b1;
    end else if (state_q == S_MRS) begin
      mode_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      acc_busy_out <= 1'b0;
      pend_write_q <= 1'b0;
      pend_addr_q <= 24'h000000;
      pend_wdata_q <= 16'h0000;
    end else if (take) begin
      acc_busy_out <= 1'b1;
      pend_write_q <= acc_write_in;
      pend_addr_q <= acc_addr_in;
      pend_wdata_q <= acc_wdata_in;
    end else if (state_q == S_FIN || acc_skip) begin
      acc_busy_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      dq_s1_q <= 16'h0000;
      dq_s2_q <= 16'h0000;
    end else begin
      dq_s1_q <= sd_dq_in;
      dq_s2_q <= dq_s1_q;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      idle_cnt_q <= 3'd0;
      last_valid_q <= 1'b0;
      last_write_q <= 1'b0;
    end else if (state_q == S_FIN) begin
      idle_cnt_q <= 3'd0;
      last_valid_q <= 1'b1;
      last_write_q <= pend_write_q;
    end else if (idle_cnt_q != 3'd7) begin
      idle_cnt_q <= idle_cnt_q + 3'd1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= S_IDLE;
      ret_q <= S_IDLE;
      wait_q <= 4'd0;
      mref_q <= 4'd0;
      cmd_q <= CMD_NOP;
      sd_cke_out <= 1'b1;
      sd_ba_out <= 2'b00;
      sd_addr_out <= 13'h0000;
      sd_dq_out <= 16'h0000;
      sd_dq_oe_n_out <= 1'b1;
      acc_done_out <= 1'b0;
      acc_rdata_out <= 16'h0000;
    end else begin
      cmd_q <= CMD_NOP;
      sd_dq_oe_n_out <= 1'b1;
      acc_done_out <= 1'b0;
      unique case (state_q)
        S_IDLE: begin
          if (self_go) begin
            cmd_q <= CMD_REF;
            sd_cke_out <= 1'b0;
            state_q <= S_SELF;
          end else if (mode_go) begin
            cmd_q <= CMD_PRE;
            sd_addr_out <= 13'h0400;
            mref_q <= MODE_REFRESHES;
            wait_q <= pre_gap;
            ret_q <= S_MREF;
            state_q <= S_WAIT;
          end else if (ref_go) begin
            cmd_q <= CMD_REF;
            wait_q <= ref_gap;
            ret_q <= S_IDLE;
            state_q <= S_WAIT;
          end else if (acc_go) begin
            cmd_q <= CMD_ACT;
            sd_ba_out <= bank_full[1:0];
            sd_addr_out <= row;
            wait_q <= rcd_gap;
            ret_q <= S_RW;
            state_q <= S_WAIT;
          end else if (acc_skip) begin
            acc_rdata_out <= 16'h0000;
            acc_done_out <= 1'b1;
          end
        end
        S_WAIT: begin
          wait_q <= wait_q - 4'd1;
          if (wait_q == 4'd1) begin
            state_q <= ret_q;
          end
        end
        S_RW: begin
          sd_addr_out <= {3'b000, col};
          sd_addr_out[AP_BIT] <= auto_ap;
          if (pend_write_q) begin
            cmd_q <= CMD_WRITE;
            sd_dq_out <= pend_wdata_q;
            sd_dq_oe_n_out <= 1'b0;
            if (auto_ap) begin
              wait_q <= wr_gap + pre_gap;
              ret_q <= S_FIN;
              state_q <= S_WAIT;
            end else if (wr_gap == 4'd0) begin
              state_q <= S_PRE;
            end else begin
              wait_q <= wr_gap;
              ret_q <= S_PRE;
              state_q <= S_WAIT;
            end
          end else begin
            cmd_q <= CMD_READ;
            // pin data stands cl cycles on, then crosses two sync flops
            wait_q <= cl + 4'd2;
            ret_q <= S_RDCAP;
            state_q <= S_WAIT;
          end
        end
        S_RDCAP: begin
          acc_rdata_out <= dq_s2_q;
          if (auto_ap) begin
            wait_q <= pre_gap;
            ret_q <= S_FIN;
            state_q <= S_WAIT;
          end else begin
            state_q <= S_PRE;
          end
        end
        S_PRE: begin
          cmd_q <= CMD_PRE;
          sd_addr_out <= 13'h0000;
          wait_q <= pre_gap;
          ret_q <= S_FIN;
          state_q <= S_WAIT;
        end
        S_FIN: begin
          acc_done_out <= 1'b1;
          state_q <= S_IDLE;
        end
        S_MREF: begin
          cmd_q <= CMD_REF;
          mref_q <= mref_q - 4'd1;
          wait_q <= ref_gap;
          ret_q <= (mref_q == 4'd1) ? S_MRS : S_MREF;
          state_q <= S_WAIT;
        end
        S_MRS: begin
          cmd_q <= CMD_MRS;
          sd_ba_out <= 2'b00;
          sd_addr_out <= mode_value_q;
          wait_q <= pre_gap;
          ret_q <= S_IDLE;
          state_q <= S_WAIT;
        end
        S_SELF: begin
          if (!self_ref) begin
            sd_cke_out <= 1'b1;
            wait_q <= ref_gap;
            ret_q <= S_IDLE;
            state_q <= S_WAIT;
          end
        end
      endcase
    end
  end

  assign sd_cs_n_out = cmd_q[3];
  assign sd_ras_n_out = cmd_q[2];
  assign sd_cas_n_out = cmd_q[1];
  assign sd_we_n_out = cmd_q[0];

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 32'h00000000;
    end else if (reg_read_in) begin
      unique case (reg_addr_in)
        BUS_CONTROL_OFF:   reg_rdata_out <= bus_ctrl_q;
        WAIT_CONTROL_OFF:  reg_rdata_out <= wait_ctrl_q;
        SDRAM_CONTROL_OFF: reg_rdata_out <= sdram_ctrl_q;
        REFRESH_CSR_OFF:   reg_rdata_out <= {24'h000000, flag_q, irq_en_q, clk_sel_q,
                                             per_match_q};
        REFRESH_CNT_OFF:   reg_rdata_out <= {24'h000000, count};
        REFRESH_CMP_OFF:   reg_rdata_out <= {24'h000000, cmp_q};
        MODE_PROGRAM_OFF:  reg_rdata_out <= {19'h00000, mode_value_q};
        STATUS_OFF:        reg_rdata_out <= {24'h000000, ref_pend_q, 1'b0,
                                             mode_pend_q, !sd_cke_out, acc_busy_out};
        default:           reg_rdata_out <= 32'h00000000;
      endcase
    end
  end

  property p_idle_after_write;
    @(posedge clk_in) disable iff (rst_in)
    (acc_done_out && last_write_q && bus_ctrl_q[W_IDLE_POS +: 2] == 2'd3)
      |=> (cmd_q != CMD_ACT)[*4];
  endproperty
  a_idle_after_write: assert property (p_idle_after_write)
    else $error("write idle gap too short");

  property p_act_only_sdram;
    @(posedge clk_in) disable iff (rst_in)
    (cmd_q == CMD_ACT) |-> $past(is_sdram && bus16);
  endproperty
  a_act_only_sdram: assert property (p_act_only_sdram)
    else $error("activate issued outside SDRAM mode");

  property p_row_to_column;
    @(posedge clk_in) disable iff (rst_in)
    (cmd_q == CMD_ACT && wait_ctrl_q[ROW_COL_POS +: 2] == 2'd1)
      |=> cmd_q == CMD_NOP ##1 cmd_q == CMD_NOP
          ##1 (cmd_q == CMD_READ || cmd_q == CMD_WRITE);
  endproperty
  a_row_to_column: assert property (p_row_to_column)
    else $error("activate to read/write spacing wrong");

  property p_cas_capture;
    @(posedge clk_in) disable iff (rst_in)
    (cmd_q == CMD_READ && wait_ctrl_q[CL_POS +: 2] == 2'd1) |-> ##4 state_q == S_RDCAP;
  endproperty
  a_cas_capture: assert property (p_cas_capture)
    else $error("read data capture at wrong cycle");

  property p_refresh_recovery;
    @(posedge clk_in) disable iff (rst_in)
    (cmd_q == CMD_REF && wait_ctrl_q[REF_REC_POS +: 2] == 2'd0) |=> (cmd_q != CMD_ACT)[*3];
  endproperty
  a_refresh_recovery: assert property (p_refresh_recovery)
    else $error("activate too soon after refresh");

  property p_compare_key;
    @(posedge clk_in) disable iff (rst_in)
    (reg_write_in && reg_addr_in == REFRESH_CMP_OFF && !key_ok) |=> $stable(cmp_q);
  endproperty
  a_compare_key: assert property (p_compare_key)
    else $error("unkeyed compare write took effect");

  property p_csr_key;
    @(posedge clk_in) disable iff (rst_in)
    (reg_write_in && reg_addr_in == REFRESH_CSR_OFF && !key_ok && !match)
      |=> $stable(clk_sel_q) && $stable(per_match_q) && $stable(irq_en_q) && $stable(flag_q);
  endproperty
  a_csr_key: assert property (p_csr_key)
    else $error("unkeyed control write took effect");

  property p_irq_gate;
    @(posedge clk_in) disable iff (rst_in)
    cmi_req_out |-> $past(flag_q) && $past(irq_en_q);
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt raised while disabled");
endmodule // sdram_area3_bus_controller
`default_nettype wire

// file: testbench/sdram_chip_model.sv
`default_nettype none
module sdram_chip_model
  import sdram_area3_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic [3:0]  cmd_in,
  input  wire logic [12:0] addr_in,
  input  wire logic [15:0] dq_in,
  input  wire logic        dq_oe_n_in,
  output logic      [15:0] dq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem_q [256];
  logic [7:0]  col_q;
  logic        rd_q = 1'b0;
  initial dq_out = 16'h5a5a;
  // read data stands only around the second edge after the read; otherwise it toggles
  always @(posedge clk_in) begin
    rd_q <= (cmd_in == CMD_READ);
    col_q <= addr_in[7:0];
    if (cmd_in == CMD_WRITE && !dq_oe_n_in) mem_q[addr_in[7:0]] <= dq_in;
    dq_out <= rd_q ? mem_q[col_q] : ~dq_out;
  end
endmodule // sdram_chip_model
`default_nettype wire

// file: testbench/sdram_area3_bus_controller_tb_top.sv
`default_nettype none
module sdram_area3_bus_controller_tb_top;
  import sdram_area3_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in = 0, rst_in = 1, reg_write_in = 0, reg_read_in = 0;
  logic        acc_req_in = 0, acc_write_in = 0, acc_busy_out, acc_done_out;
  logic        sd_cke_out, sd_cs_n_out, sd_ras_n_out, sd_cas_n_out, sd_we_n_out;
  logic        sd_dq_oe_n_out, cmi_req_out;
  logic [7:0]  reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out;
  logic [23:0] acc_addr_in = 24'h0;
  logic [15:0] acc_wdata_in = 16'h0, acc_rdata_out, sd_dq_in, sd_dq_out;
  logic [1:0]  sd_ba_out;
  logic [12:0] sd_addr_out;
  int          n_fail = 0, check_count = 0, cyc = 0, done_c = 0;
  int          nref = 0, nref_all = 0, ref_c = 0, gap = 0;
  wire logic [3:0] cmd = {sd_cs_n_out, sd_ras_n_out, sd_cas_n_out, sd_we_n_out};
  always #5 clk_in = ~clk_in;
  sdram_area3_bus_controller uut (.*);
  sdram_chip_model chip (.clk_in(clk_in), .cmd_in(cmd), .addr_in(sd_addr_out),
    .dq_in(sd_dq_out), .dq_oe_n_in(sd_dq_oe_n_out), .dq_out(sd_dq_in));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic hung();
    check(32'h0, 32'h1);
    tally_and_finish();
  endtask
  // command monitor: refresh spacing, refreshes since precharge
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cmd == CMD_PRE) nref <= 0;
    if (cmd == CMD_REF) begin
      nref <= nref + 1;
      nref_all <= nref_all + 1;
      gap <= cyc - ref_c;
      ref_c <= cyc;
    end
    if (cmi_req_out !== 1'b0) check({31'h0, cmi_req_out}, 32'h0);
  end
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge clk_in);
    reg_write_in <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge clk_in);
    reg_read_in <= 1'b0;
    #1 check(reg_rdata_out, exp);
  endtask
  task automatic acc(input logic wr, input logic [23:0] a, input logic [15:0] d,
                     output logic [15:0] r);
    int   act_c = 0, rw_c = 0, i = 0;
    logic ap = 1'b0;
    @(posedge clk_in);
    acc_req_in <= 1'b1;
    acc_write_in <= wr;
    acc_addr_in <= a;
    acc_wdata_in <= d;
    do begin
      @(posedge clk_in);
      i++;
    end while (acc_busy_out !== 1'b0 && i < 100);
    if (i == 100) hung();
    acc_req_in <= 1'b0;
    for (i = 0; i < 100 && acc_done_out !== 1'b1; i++) begin
      @(posedge clk_in);
      if (cmd == CMD_ACT) act_c = cyc;
      if (cmd == CMD_WRITE) check({31'h0, sd_dq_oe_n_out}, 32'h0);
      if (cmd == CMD_READ || cmd == CMD_WRITE) begin
        rw_c = cyc;
        ap = sd_addr_out[AP_BIT];
      end
    end
    if (i == 100) hung();
    check(rw_c - act_c, 32'd3);
    check({31'h0, ap}, 32'h1);
    check({31'h0, act_c - done_c >= 5}, 32'h1);
    done_c = cyc;
    r = acc_rdata_out;
  endtask
  task automatic reset_values();
    reg_rd(BUS_CONTROL_OFF, 32'h36db4400);
    reg_rd(WAIT_CONTROL_OFF, 32'h00000480);
    reg_rd(SDRAM_CONTROL_OFF, 32'h00000808);
    reg_rd(REFRESH_CSR_OFF, 32'h00000008);
    reg_rd(REFRESH_CMP_OFF, 32'h0000009c);
    reg_rd(8'h40, 32'h0);
  endtask
  task automatic mode_program();
    int i;
    reg_wr(MODE_PROGRAM_OFF, 32'h00000220);
    for (i = 0; i < 300 && cmd != CMD_MRS; i++) @(posedge clk_in);
    if (i == 300) hung();
    check(nref, 32'd8);
    check({19'h0, sd_addr_out}, 32'h220);
  endtask
  task automatic protect_and_refresh();
    int i;
    reg_wr(REFRESH_CMP_OFF, 32'h00000010);
    reg_rd(REFRESH_CMP_OFF, 32'h9c);
    reg_wr(REFRESH_CSR_OFF, 32'h00000000);
    reg_rd(REFRESH_CSR_OFF, 32'h08);
    reg_wr(REFRESH_CMP_OFF, {WRITE_KEY, 16'h0010});
    reg_wr(REFRESH_CNT_OFF, {WRITE_KEY, 16'h0000});
    i = nref_all;
    repeat (300) if (nref_all < i + 3) @(posedge clk_in);
    if (nref_all < i + 3) hung();
    check({31'h0, gap inside {64, 68}}, 32'h1);
    reg_rd(REFRESH_CSR_OFF, 32'h88);
    reg_wr(REFRESH_CSR_OFF, {WRITE_KEY, 16'h0008});
    reg_rd(REFRESH_CSR_OFF, 32'h08);
  endtask
  task automatic accesses();
    logic [15:0] r;
    acc(1'b1, 24'h000012, 16'hbeef, r);
    acc(1'b0, 24'h000012, 16'h0000, r);
    check({16'h0, r}, 32'hbeef);
    acc(1'b1, 24'h000034, 16'h1234, r);
    acc(1'b0, 24'h000034, 16'h0000, r);
    acc(1'b0, 24'h000012, 16'h0000, r);
    check({16'h0, r}, 32'hbeef);
  endtask
  initial begin
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    reset_values();
    mode_program();
    protect_and_refresh();
    accesses();
    tally_and_finish();
  end
endmodule // sdram_area3_bus_controller_tb_top
`default_nettype wire
